// File: src/ahp_params.svh
`ifndef AHP_PARAMS_SVH
`define AHP_PARAMS_SVH

// Clock 250 MHz, period in ps
`define AHP_CLK_PERIOD_PS 4000
// Burn-out hold times in us, cycle counts derived
`define AHP_BO_LONG_US 15600
`define AHP_BO_SHORT_US 7800
// 64-bit product: the picosecond totals do not fit in 32 bits
`define AHP_BO_LONG_CYC ((`AHP_BO_LONG_US * 64'd1000000 + `AHP_CLK_PERIOD_PS - 1) / `AHP_CLK_PERIOD_PS)
`define AHP_BO_SHORT_CYC ((`AHP_BO_SHORT_US * 64'd1000000 + `AHP_CLK_PERIOD_PS - 1) / `AHP_CLK_PERIOD_PS)
// Queue pulse least time in ns
`define AHP_QUEUE_NS 4000
`define AHP_QUEUE_CYC ((`AHP_QUEUE_NS * 1000 + `AHP_CLK_PERIOD_PS - 1) / `AHP_CLK_PERIOD_PS)
// Debounce codes
`define AHP_DEB_SHORT 2'h1
`define AHP_DEB_LONG 2'h2
// Frame layout
`define AHP_FRAME_BITS 72
`define AHP_STATUS_LEAD 4'hc
`define AHP_CMD_BITS 8
`define AHP_CNT_W 24

`endif

// File: src/ahp_pkg.sv
package ahp_pkg;

  typedef struct packed {
    logic [4:0] burnout_status;
    logic [1:0] pin_levels;
    logic [23:0] ch1;
    logic [23:0] ch2;
  } ahp_sample_t;

  typedef struct packed {
    logic burnout_irq_enable;
    logic range_irq_enable;
    logic queue_irq_enable;
    logic clock_loss_irq_enable;
    logic bad_command_irq_enable;
  } ahp_irq_en_t;

  typedef struct packed {
    logic burnout;
    logic range;
    logic queue;
    logic clock_loss;
    logic bad_command;
  } ahp_irq_src_t;

  typedef enum logic [1:0] {
    AHP_IDLE,
    AHP_CMD,
    AHP_READ
  } ahp_state_t;

endpackage

// File: src/ahp_pulse_hold.sv
`timescale 1ns/100ps
`include "ahp_params.svh"

// Stretches a trigger: output stays high at least len_i cycles after the last trigger
module ahp_pulse_hold import ahp_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic trig_i,
  input wire logic [`AHP_CNT_W-1:0] len_i,
  output logic hold_o
);

  logic [`AHP_CNT_W-1:0] cnt_q;
  logic [`AHP_CNT_W-1:0] cnt_d;

  assign cnt_d = trig_i ? len_i : (cnt_q != '0) ? cnt_q - `AHP_CNT_W'd1 : cnt_q;
  assign hold_o = trig_i || (cnt_q != '0);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// File: src/ahp_host_port.sv
`timescale 1ns/100ps
`include "ahp_params.svh"

// Contract
// - Five interrupt sources combine onto one selected pin, only if pin output enabled.
// - Burn-out interrupt holds about 15.6 ms (code 2) or 7.8 ms (code 1).
// - Range interrupt holds at least one output data rate period.
// - Queue interrupt pulse lasts at least about 4 us.
// - Clock-loss interrupt stays high until software clear or reset.
// - Only first bad command recorded; interrupt holds until its status cleared.
// - Chip select high resets serial state, ignores clock and data, floats data out.
// - Ready output asserts on conversion complete regardless of chip select.
// - Data input sampled on each falling serial clock edge.
// - Each output bit shifted onto data out on rising serial clock edge.
// - No output data until start input has risen once.
// - Ready goes low when a new conversion result is available.
// - Ready returns high on first falling edge of a read; MSB on first rising.
// - Frame starts with 24-bit status led by 1100, then two channel results.
module ahp_host_port import ahp_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic start_i,
  input wire logic conv_done_i,
  input wire ahp_sample_t sample_i,
  input wire logic [7:0] valid_cmd_mask_i,
  input wire ahp_irq_en_t irq_en_i,
  input wire logic [1:0] burnout_debounce_i,
  input wire logic [23:0] odr_cycles_i,
  input wire logic irq_pin_select_i,
  input wire logic irq_pin_out_en_i,
  input wire logic burnout_event_i,
  input wire logic range_event_i,
  input wire logic queue_event_i,
  input wire logic clock_loss_event_i,
  input wire logic clock_loss_clear_i,
  input wire logic bad_command_clear_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic conversion_ready_n_o,
  output logic [1:0] irq_pin_o,
  output logic [1:0] irq_pin_oe_o,
  output logic continuous_read_cmd_o,
  output logic bad_command_status_o,
  output logic [7:0] bad_command_code_o,
  output logic [7:0] cmd_byte_o,
  output logic cmd_valid_o
);

  localparam logic [7:0] CMD_READ_CONT = 8'h10;
  localparam logic [7:0] CMD_STOP_CONT = 8'h11;
  localparam logic [7:0] CMD_READ_ONCE = 8'h12;
  localparam logic [6:0] FRAME_LAST = 7'(`AHP_FRAME_BITS - 1);

  // Pin synchronisers: first stage read only by second
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sclk_prev_q;
  logic start_prev_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 4'h1;
      sync2_q <= 4'h1;
      sclk_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= {start_i, din_i, sclk_i, cs_n_i};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[1];
      start_prev_q <= sync2_q[3];
    end
  end

  wire cs_n_s = sync2_q[0];
  wire sclk_s = sync2_q[1];
  wire din_s = sync2_q[2];
  wire start_s = sync2_q[3];
  wire sel = !cs_n_s;
  // Serial clock edges are only seen while selected; start edge always
  wire sclk_rise = sel && sclk_s && !sclk_prev_q;
  wire sclk_fall = sel && !sclk_s && sclk_prev_q;
  wire start_rise = start_s && !start_prev_q;

  // Serial state
  ahp_state_t state_q;
  ahp_state_t state_d;
  logic [2:0] bit_cnt_q;
  logic [7:0] cmd_sh_q;
  logic [6:0] frame_pos_q;
  logic [`AHP_FRAME_BITS-1:0] frame_q;
  logic [`AHP_FRAME_BITS-1:0] shadow_q;
  logic started_q;
  logic first_fall_q;
  logic cont_q;
  logic bad_seen_q;
  logic [7:0] bad_code_q;
  logic rdy_n_q;
  logic dout_q;
  logic dout_oe_q;
  logic [7:0] cmd_q;
  logic cmd_vld_q;

  function automatic logic [`AHP_FRAME_BITS-1:0] build_frame(input ahp_sample_t s);
    build_frame = {`AHP_STATUS_LEAD, s.burnout_status, s.pin_levels, 5'h00, 8'h00, s.ch1, s.ch2};
  endfunction

  wire [7:0] cmd_next = {cmd_sh_q[6:0], din_s};
  wire cmd_done = sclk_fall && (state_q == AHP_CMD) && (bit_cnt_q == 3'h7);
  wire cmd_known = valid_cmd_mask_i[cmd_next[2:0]] || (cmd_next == CMD_READ_CONT) ||
                   (cmd_next == CMD_STOP_CONT) || (cmd_next == CMD_READ_ONCE);
  wire cmd_bad = cmd_done && !cmd_known;
  wire go_read = cmd_done && (cmd_next == CMD_READ_ONCE || cmd_next == CMD_READ_CONT);
  // In continuous mode selection alone starts a read, no opcode,
  // so the MSB already leaves on the first rising edge of the frame
  wire cont_read = sel && (state_q == AHP_IDLE) && cont_q && started_q;
  wire new_data = conv_done_i && started_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      AHP_IDLE: state_d = cont_read ? AHP_READ : (sclk_fall ? AHP_CMD : AHP_IDLE);
      AHP_CMD: state_d = go_read ? AHP_READ : (cmd_done ? AHP_IDLE : AHP_CMD);
      AHP_READ: state_d = (sclk_fall && cont_q && din_s) ? AHP_CMD : AHP_READ;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= AHP_IDLE;
      bit_cnt_q <= 3'h0;
      cmd_sh_q <= 8'h00;
      frame_pos_q <= 7'h00;
      first_fall_q <= 1'b0;
    end else if (ce_i) begin
      if (cs_n_s) begin
        state_q <= AHP_IDLE;
        bit_cnt_q <= 3'h0;
        cmd_sh_q <= 8'h00;
        frame_pos_q <= 7'h00;
        first_fall_q <= 1'b0;
      end else begin
        state_q <= state_d;
        if (sclk_fall && state_q != AHP_READ) begin
          cmd_sh_q <= cmd_next;
          bit_cnt_q <= (state_q == AHP_IDLE) ? 3'h1 : bit_cnt_q + 3'h1;
        end
        if (state_d == AHP_READ && state_q != AHP_READ) begin
          frame_pos_q <= 7'h00;
          first_fall_q <= 1'b1;
        end else if (sclk_fall) begin
          first_fall_q <= 1'b0;
        end
        if (state_q == AHP_READ && sclk_rise) begin
          // Wraps so extra clocks repeat the frame from its MSB
          frame_pos_q <= (frame_pos_q == FRAME_LAST) ? 7'h00 : frame_pos_q + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      started_q <= 1'b0;
      cont_q <= 1'b0;
      bad_seen_q <= 1'b0;
      bad_code_q <= 8'h00;
      rdy_n_q <= 1'b1;
      dout_q <= 1'b0;
      dout_oe_q <= 1'b0;
      frame_q <= '0;
      shadow_q <= '0;
      cmd_q <= 8'h00;
      cmd_vld_q <= 1'b0;
    end else if (ce_i) begin
      if (start_rise) begin
        started_q <= 1'b1;
      end
      if (cmd_done && cmd_next == CMD_READ_CONT) begin
        cont_q <= 1'b1;
      end else if (cmd_done && cmd_next == CMD_STOP_CONT) begin
        cont_q <= 1'b0;
      end
      if (cmd_bad && !bad_seen_q) begin
        bad_seen_q <= 1'b1;
        bad_code_q <= cmd_next;
      end else if (bad_command_clear_i && !cmd_bad) begin
        bad_seen_q <= 1'b0;
      end
      if (new_data) begin
        shadow_q <= build_frame(sample_i);
      end
      if (new_data) begin
        rdy_n_q <= 1'b0;
      end else if (state_q == AHP_READ && first_fall_q && sclk_fall) begin
        rdy_n_q <= 1'b1;
      end
      if (state_d == AHP_READ && state_q != AHP_READ) begin
        frame_q <= shadow_q;
      end
      dout_oe_q <= sel;
      if (cs_n_s || !started_q) begin
        dout_q <= 1'b0;
      end else if (state_q == AHP_READ && sclk_rise) begin
        dout_q <= frame_q[FRAME_LAST - frame_pos_q];
      end
      cmd_vld_q <= cmd_done && cmd_known;
      if (cmd_done) begin
        cmd_q <= cmd_next;
      end
    end
  end

  // Interrupt sources
  ahp_irq_src_t src;
  logic clk_loss_q;
  logic [`AHP_CNT_W-1:0] bo_len;
  logic [1:0] irq_q;
  logic [1:0] irq_oe_q;

  assign bo_len = (burnout_debounce_i == `AHP_DEB_LONG) ? `AHP_CNT_W'(`AHP_BO_LONG_CYC) :
                  (burnout_debounce_i == `AHP_DEB_SHORT) ? `AHP_CNT_W'(`AHP_BO_SHORT_CYC) :
                  `AHP_CNT_W'd1;

  ahp_pulse_hold u_bo_hold (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .trig_i(burnout_event_i),
    .len_i(bo_len),
    .hold_o(src.burnout)
  );

  ahp_pulse_hold u_range_hold (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .trig_i(range_event_i),
    .len_i(odr_cycles_i),
    .hold_o(src.range)
  );

  ahp_pulse_hold u_queue_hold (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .trig_i(queue_event_i),
    .len_i(`AHP_CNT_W'(`AHP_QUEUE_CYC)),
    .hold_o(src.queue)
  );

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_loss_q <= 1'b0;
    end else if (ce_i) begin
      if (clock_loss_event_i) begin
        clk_loss_q <= 1'b1;
      end else if (clock_loss_clear_i) begin
        clk_loss_q <= 1'b0;
      end
    end
  end

  assign src.clock_loss = clk_loss_q;
  assign src.bad_command = bad_seen_q;

  wire any_irq = |(src & irq_en_i);
  wire [1:0] irq_d = irq_pin_select_i ? {any_irq, 1'b0} : {1'b0, any_irq};

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q <= 2'h0;
      irq_oe_q <= 2'h0;
    end else if (ce_i) begin
      irq_q <= irq_pin_out_en_i ? irq_d : 2'h0;
      irq_oe_q <= irq_pin_out_en_i ? (irq_pin_select_i ? 2'h2 : 2'h1) : 2'h0;
    end
  end

  assign dout_o = dout_q;
  assign dout_oe_o = dout_oe_q;
  assign conversion_ready_n_o = rdy_n_q;
  assign irq_pin_o = irq_q;
  assign irq_pin_oe_o = irq_oe_q;
  assign continuous_read_cmd_o = cont_q;
  assign bad_command_status_o = bad_seen_q;
  assign bad_command_code_o = bad_code_q;
  assign cmd_byte_o = cmd_q;
  assign cmd_valid_o = cmd_vld_q;

endmodule

// File: sim/ahp_host_port_properties.sv
`timescale 1ns/100ps
module ahp_host_port_chk import ahp_pkg::*; (
  input logic ref_clk_i,
  input logic resetn_i,
  input logic ce_i,
  input logic cs_n_i,
  input logic sclk_i,
  input logic start_i,
  input logic conv_done_i,
  input ahp_irq_en_t irq_en_i,
  input logic irq_pin_select_i,
  input logic irq_pin_out_en_i,
  input logic clock_loss_event_i,
  input logic bad_command_clear_i,
  input logic dout_o,
  input logic dout_oe_o,
  input logic conversion_ready_n_o,
  input logic [1:0] irq_pin_o,
  input logic continuous_read_cmd_o,
  input logic bad_command_status_o,
  input logic [7:0] bad_command_code_o
);
  logic seen_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) seen_q <= 1'b0;
    else seen_q <= seen_q | start_i;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_NO_START: assert property (!seen_q |-> conversion_ready_n_o && !dout_o)
    else $error("output before start");
  AST_RDY_SET: assert property (conv_done_i && $past(seen_q, 8) |=> !conversion_ready_n_o)
    else $error("ready missing");
  AST_RDY_CLR: assert property (
    $fell(sclk_i) && !cs_n_i && continuous_read_cmd_o && !conversion_ready_n_o |-> ##[2:6] conversion_ready_n_o)
    else $error("ready not released");
  AST_OE_CS: assert property (cs_n_i [*5] |-> !dout_oe_o)
    else $error("driven while idle");
  AST_OUT_EN: assert property (!irq_pin_out_en_i [*2] |-> irq_pin_o == 2'h0)
    else $error("pin while off");
  AST_DIS: assert property ((irq_en_i == 5'h00) [*2] |-> irq_pin_o == 2'h0)
    else $error("pin while disabled");
  AST_CLK_LOSS: assert property (
    ce_i && clock_loss_event_i && irq_en_i.clock_loss_irq_enable && irq_pin_out_en_i && $stable(irq_pin_select_i)
    |-> ##[1:3] irq_pin_o[irq_pin_select_i])
    else $error("clock loss silent");
  AST_BAD_HOLD: assert property (
    bad_command_status_o && !bad_command_clear_i |=> bad_command_status_o && $stable(bad_command_code_o))
    else $error("bad record lost");
endmodule
bind ahp_host_port ahp_host_port_chk chk_u (
  .ref_clk_i, .resetn_i, .ce_i, .cs_n_i, .sclk_i, .start_i, .conv_done_i, .irq_en_i, .irq_pin_select_i,
  .irq_pin_out_en_i, .clock_loss_event_i, .bad_command_clear_i, .dout_o, .dout_oe_o,
  .conversion_ready_n_o, .irq_pin_o, .continuous_read_cmd_o, .bad_command_status_o, .bad_command_code_o);

// File: sim/ahp_spi_host.sv
`timescale 1ns/100ps
module ahp_spi_host (
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Data in moves mid low phase, away from the sampling fall
  task automatic xfer(input logic [7:0] op, input int nop, input int nrd, output logic [71:0] rx);
    rx = 72'h0;
    cs_n_o = 1'b0;
    for (int i = 0; i < nop + nrd; i++) begin
      #40 din_o = (i < nop) ? op[7 - i] : 1'b0;
      #40 sclk_o = 1'b1;
      #80 rx = {rx[70:0], dout_i};
      sclk_o = 1'b0;
    end
    #20 cs_n_o = 1'b1;
    din_o = ~din_o;
    #40;
  endtask
endmodule

// File: sim/ahp_host_port_tb_top.sv
`timescale 1ns/100ps
module ahp_host_port_tb_top import ahp_pkg::*; ;
  logic clk, rst_n, start, conv, sel, out_en, cs_n, sclk, din, dout, oe, rdy_n, cont, bad_st, ce, cmd_vld;
  logic [1:0] deb, pin, pin_oe;
  logic [5:0] ev;
  logic [7:0] bad_code, cmd_byte;
  logic [71:0] rx;
  ahp_sample_t smp;
  ahp_irq_en_t en;
  ahp_sample_t exp_q[$];
  int fail_count, checks_done, cyc, vld_cnt;
  int seed = 32'h825d_cc89;
  ahp_host_port dut_u (.ref_clk_i(clk), .resetn_i(rst_n), .ce_i(ce), .cs_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .start_i(start), .conv_done_i(conv), .sample_i(smp), .valid_cmd_mask_i(8'h00),
    .irq_en_i(en), .burnout_debounce_i(deb), .odr_cycles_i(24'h00_0064), .irq_pin_select_i(sel),
    .irq_pin_out_en_i(out_en), .burnout_event_i(ev[5]), .range_event_i(ev[4]), .queue_event_i(ev[3]),
    .clock_loss_event_i(ev[2]), .clock_loss_clear_i(ev[1]), .bad_command_clear_i(ev[0]),
    .dout_o(dout), .dout_oe_o(oe), .conversion_ready_n_o(rdy_n), .irq_pin_o(pin), .irq_pin_oe_o(pin_oe),
    .continuous_read_cmd_o(cont), .bad_command_status_o(bad_st), .bad_command_code_o(bad_code),
    .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_vld));
  // A floating data line shows the inverse of the last level to the host
  ahp_spi_host host_u (.dout_i(oe ? dout : ~dout), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  // Counted on the falling edge, away from the edge that launches the pulse
  always @(negedge clk) begin
    if (cmd_vld === 1'b1) vld_cnt++;
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [71:0] frame(ahp_sample_t s);
    return {4'hc, s.burnout_status, s.pin_levels, 13'h0000, s.ch1, s.ch2};
  endfunction
  task automatic convert();
    smp = 55'({$random(seed), $random(seed)});
    exp_q.push_back(smp);
    conv = 1'b1;
    tick(1);
    conv = 1'b0;
    tick(3);
    chk("ready_n", rdy_n, 1'b0);
  endtask
  task automatic rd(input logic [7:0] op, input int nop);
    host_u.xfer(op, nop, 72, rx);
    chk("frame", rx, frame(exp_q.pop_front()));
  endtask
  // Pulse events and clears, then look at the pin after w cycles
  task automatic irq(input logic [5:0] m, input int w, input logic [1:0] e);
    ev = m;
    tick(1);
    ev = 6'h00;
    tick(w);
    chk("irq_pin", pin, e);
  endtask
  initial begin
    {rst_n, start, conv, sel, out_en, ev, deb, en, smp} = '0;
    ce = 1'b1;
    tick(20);
    rst_n = 1'b1;
    tick(5);
    conv = 1'b1;
    tick(1);
    conv = 1'b0;
    tick(3);
    chk("ready_n", rdy_n, 1'b1);
    host_u.xfer(8'h12, 8, 72, rx);
    chk("dout", rx, 72'h0);
    start = 1'b1;
    tick(10);
    for (int i = 0; i < 3; i++) begin
      convert();
      rd(8'h12, 8);
      chk("ready_n", rdy_n, 1'b1);
      chk("cmd", cmd_byte, 8'h12);
    end
    chk("dout_oe", oe, 1'b0);
    sel = 1'b1;
    out_en = 1'b1;
    en = 5'h01;
    host_u.xfer(8'h5a, 8, 0, rx);
    host_u.xfer(8'h3c, 8, 0, rx);
    chk("bad_cmd", {bad_st, bad_code}, 9'h15a);
    irq(6'h00, 1, 2'h2);
    irq(6'h01, 3, 2'h0);
    en = 5'h02;
    irq(6'h04, 50, 2'h2);
    irq(6'h02, 3, 2'h0);
    en = 5'h0c;
    irq(6'h18, 110, 2'h2);
    irq(6'h00, 880, 2'h2);
    irq(6'h00, 40, 2'h0);
    en = 5'h08;
    irq(6'h10, 95, 2'h2);
    irq(6'h00, 20, 2'h0);
    en = 5'h00;
    irq(6'h34, 5, 2'h0);
    irq(6'h02, 150, 2'h0);
    en = 5'h1f;
    out_en = 1'b0;
    irq(6'h04, 5, 2'h0);
    chk("irq_oe", pin_oe, 2'h0);
    out_en = 1'b1;
    irq(6'h00, 3, 2'h2);
    chk("irq_oe", pin_oe, 2'h2);
    irq(6'h02, 3, 2'h0);
    ce = 1'b0;
    irq(6'h04, 5, 2'h0);
    ce = 1'b1;
    irq(6'h00, 3, 2'h0);
    en = 5'h10;
    deb = 2'h1;
    irq(6'h20, 3000, 2'h2);
    sel = 1'b0;
    irq(6'h00, 2, 2'h1);
    chk("irq_oe", pin_oe, 2'h1);
    host_u.xfer(8'h10, 8, 0, rx);
    chk("cont", cont, 1'b1);
    for (int i = 0; i < 3; i++) begin
      convert();
      rd(8'h00, 0);
    end
    chk("cmd_valid", vld_cnt, 72'd5);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(5);
    chk("cont_pin", {cont, pin}, 3'h0);
    print_verdict();
  end
endmodule
